// >>> hcig_consts.svh
// constants of the host control, interrupt and port block
// assumes inclusion by bare name from the package and both ends
`ifndef HCIG_CONSTS_SVH
`define HCIG_CONSTS_SVH
// ****************************************
// bus addresses of the register groups
// ****************************************
`define HCIG_GRP_FUNC      8'he8
`define HCIG_GRP_CS_WR     8'he9
`define HCIG_GRP_IRQ_RD    8'hea
`define HCIG_GRP_RATE_RD   8'heb
`define HCIG_GRP_CS_RD     8'hec
`define HCIG_GRP_PC_RD     8'hed
// ****************************************
// command addresses and field positions
// ****************************************
`define HCIG_CMD_SYS       4'h0
`define HCIG_CMD_IRQ_EN    4'h8
`define HCIG_CMD_PORT_OUT  4'ha
`define HCIG_POS_PULSE     3
`define HCIG_POS_DOEN      1
`define HCIG_CHIP_ADDR     2'h0
`define HCIG_ADDR_BITS     5'h08
`define HCIG_DATA_BITS     5'h10
// ****************************************
// reset values
// ****************************************
`define HCIG_IRQ_EN_RST    8'h00
`define HCIG_PORT_OUT_RST  4'h0
`define HCIG_SYNC_RST      8'h08
// ****************************************
// timing
// ****************************************
`define HCIG_PULSE_HALVES  2'h2
`define HCIG_CLK_NS        5
`define HCIG_CL_PERIOD_NS  160
`define HCIG_CL_HALF_CYC   (`HCIG_CL_PERIOD_NS / (2 * `HCIG_CLK_NS))
// ****************************************
// host user registers
// ****************************************
`define HCIG_REG_ADDR      4'h0
`define HCIG_REG_WDATA     4'h1
`define HCIG_REG_GO        4'h2
`define HCIG_REG_STATUS    4'h3
`define HCIG_REG_RDATA     4'h4
`endif

// >>> hcig_device.sv
// device end: serial register groups, interrupt combiner, parallel port
// assumes one sys_clk domain; link and port pins arrive asynchronously
//
// Summary of operation
// - direction pin high inputs, low outputs
// - command ten upper nibble drives the pins
// - host writes zeros in lower nibble
// - input pins captured into rate group bits
// - interrupt on lock or data info change
// - interrupt idles high, low on event
// - pulse half to one fs; level
// - per-source enables, output ORs enabled sources
// - sources one to four event kinds
// - sources five to eight event kinds
// - source data in upper byte of group
// - sources one and five read live
// - reading interrupt group clears pending
// - host keeps amplifier continuous for two, three
// - bus address selects register group
// - address always precedes data
// - read data is three-state driver
// - chip, reserved, command, then data bits
// - data released low, driven, released again
// - mode bit resets to level mode
`timescale 1ns/1ps
`include "hcig_consts.svh"
module hcig_device (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // host link
    hcig_link_if.dev         link,
    // general-purpose port
    input  wire logic        port_direction_pin,
    input  wire logic [3:0]  gp_in,
    output logic      [3:0]  gp_out,
    output logic      [3:0]  gp_oe,
    // interrupt sources
    input  wire logic        lock_error_flag,
    input  wire logic        input_present,
    input  wire logic        rate_change_event,
    input  wire logic        chan_status_update,
    input  wire logic        nonaudio_flag,
    input  wire logic        burst_preamble_update,
    input  wire logic        slave_slip_event,
    input  wire logic        emphasis_flag,
    // rate data and word-clock half tick
    input  wire logic [11:0] rate_data,
    input  wire logic        fs_half_tick,
    // interrupt
    output logic             irq_n
);
    import hcig_pkg::*;

    // ****************************************
    // three-stage pin synchroniser
    // ****************************************
    logic [7:0]      raw;
    logic [7:0]      s1_reg;
    logic [7:0]      s2_reg;
    logic [7:0]      s3_reg;
    logic [7:0]      st_reg;
    logic [7:0]      st_next;
    logic [7:0]      agree;

    assign raw     = {gp_in, port_direction_pin, link.di, link.ce, link.cl};
    assign agree   = ~(s2_reg ^ s3_reg);
    assign st_next = (agree & s2_reg) | (~agree & st_reg);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s1_reg <= `HCIG_SYNC_RST;
            s2_reg <= `HCIG_SYNC_RST;
            s3_reg <= `HCIG_SYNC_RST;
            st_reg <= `HCIG_SYNC_RST;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            st_reg <= st_next;
        end
    end

    logic cl_rise;
    logic cl_fall;
    logic ce_rise;
    logic ce_fall;
    logic di_bit;
    logic dir_in;

    assign cl_rise = st_next[0] & ~st_reg[0];
    assign cl_fall = ~st_next[0] & st_reg[0];
    assign ce_rise = st_next[1] & ~st_reg[1];
    assign ce_fall = ~st_next[1] & st_reg[1];
    assign di_bit  = st_next[2];
    assign dir_in  = st_reg[3];

    // ****************************************
    // serial frame decoder
    // ****************************************
    hcig_dev_state_t state_reg;
    hcig_dev_state_t state_next;
    logic [4:0]      cnt_reg;
    logic [4:0]      cnt_next;
    logic [7:0]      addr_reg;
    logic [7:0]      addr_next;
    logic [15:0]     data_reg;
    logic [15:0]     data_next;
    logic [15:0]     out_reg;
    logic [15:0]     out_next;
    logic            oe_reg;
    logic            oe_next;
    logic            doen_reg;
    logic            pulse_mode_reg;
    logic [7:0]      irq_en_reg;
    logic [3:0]      port_out_reg;
    logic [3:0]      port_in_reg;
    logic [7:0]      pend_reg;
    logic [3:0]      lvl_reg;
    logic [1:0]      pulse_reg;
    logic [1:0]      pulse_next;

    logic            addr_done;
    logic            is_read_grp;
    logic            rd_hit;
    logic            irq_read;
    logic            wr_commit;
    logic [3:0]      cmd;
    logic [7:0]      val;
    logic [7:0]      src_view;
    logic [15:0]     read_word;

    assign addr_done   = cnt_reg == `HCIG_ADDR_BITS;
    assign is_read_grp = (addr_reg == `HCIG_GRP_IRQ_RD) || (addr_reg == `HCIG_GRP_RATE_RD)
                       || (addr_reg == `HCIG_GRP_CS_RD) || (addr_reg == `HCIG_GRP_PC_RD);
    assign rd_hit      = (state_reg == ST_ADDR) && ce_rise && addr_done && is_read_grp;
    assign irq_read    = rd_hit && (addr_reg == `HCIG_GRP_IRQ_RD);
    assign cmd         = data_reg[7:4];
    assign val         = data_reg[15:8];
    assign wr_commit   = (state_reg == ST_WRITE) && ce_fall && (cnt_reg == `HCIG_DATA_BITS)
                       && (data_reg[1:0] == `HCIG_CHIP_ADDR) && (data_reg[3:2] == 2'h0);
    assign src_view    = {pend_reg[7:5], nonaudio_flag, pend_reg[3:1], lock_error_flag};
    assign read_word   = (addr_reg == `HCIG_GRP_IRQ_RD)  ? {src_view, 8'h00} :
                         (addr_reg == `HCIG_GRP_RATE_RD) ? {rate_data, port_in_reg} :
                         16'h0000;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        addr_next  = addr_reg;
        data_next  = data_reg;
        out_next   = out_reg;
        oe_next    = oe_reg;
        case (state_reg)
            ST_ADDR: begin
                if (cl_rise && !addr_done) begin
                    addr_next = {di_bit, addr_reg[7:1]};
                    cnt_next  = cnt_reg + 5'h01;
                end
                if (ce_rise) begin
                    cnt_next = 5'h00;
                    if (addr_done && addr_reg == `HCIG_GRP_FUNC) begin
                        state_next = ST_WRITE;
                    end else if (rd_hit) begin
                        state_next = ST_READ;
                        out_next   = read_word;
                        oe_next    = ~doen_reg;
                    end else begin
                        state_next = ST_SKIP;
                    end
                end
            end
            ST_WRITE: begin
                if (cl_rise && cnt_reg != `HCIG_DATA_BITS) begin
                    data_next = {di_bit, data_reg[15:1]};
                    cnt_next  = cnt_reg + 5'h01;
                end
                if (ce_fall) begin
                    state_next = ST_ADDR;
                    cnt_next   = 5'h00;
                end
            end
            ST_READ: begin
                if (cl_fall) begin
                    out_next = {1'b0, out_reg[15:1]};
                end
                if (ce_fall) begin
                    state_next = ST_ADDR;
                    oe_next    = 1'b0;
                end
            end
            ST_SKIP: begin
                if (ce_fall) begin
                    state_next = ST_ADDR;
                end
            end
            default: begin
                state_next = ST_ADDR;
                cnt_next   = 5'h00;
                oe_next    = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_ADDR;
            cnt_reg   <= 5'h00;
            addr_reg  <= 8'h00;
            data_reg  <= 16'h0000;
            out_reg   <= 16'h0000;
            oe_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            addr_reg  <= addr_next;
            data_reg  <= data_next;
            out_reg   <= out_next;
            oe_reg    <= oe_next;
        end
    end

    // three-state read data
    assign link.do_out = out_reg[0];
    assign link.do_oe  = oe_reg;

    // ****************************************
    // command registers
    // ****************************************
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_en_reg     <= `HCIG_IRQ_EN_RST;
            pulse_mode_reg <= 1'b0;
            doen_reg       <= 1'b0;
            port_out_reg   <= `HCIG_PORT_OUT_RST;
        end else if (wr_commit) begin
            if (cmd == `HCIG_CMD_IRQ_EN) begin
                irq_en_reg <= val;
            end
            if (cmd == `HCIG_CMD_PORT_OUT) begin
                port_out_reg <= val[7:4];
            end
            if (cmd == `HCIG_CMD_SYS) begin
                pulse_mode_reg <= val[`HCIG_POS_PULSE];
                doen_reg       <= val[`HCIG_POS_DOEN];
            end
        end
    end

    // ****************************************
    // general-purpose port
    // ****************************************
    assign gp_out = port_out_reg;
    assign gp_oe  = {4{~dir_in}};

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            port_in_reg <= 4'h0;
        end else if (dir_in) begin
            port_in_reg <= st_reg[7:4];
        end
    end

    // ****************************************
    // interrupt sources and output
    // ****************************************
    logic [3:0] lvl;
    logic [3:0] lvl_chg;
    logic [7:0] evt;
    logic [7:0] hit;
    logic [7:0] pend_next;

    assign lvl       = {emphasis_flag, nonaudio_flag, input_present, lock_error_flag};
    assign lvl_chg   = lvl ^ lvl_reg;
    assign evt       = {lvl_chg[3], slave_slip_event, burst_preamble_update, lvl_chg[2],
                        chan_status_update, rate_change_event, lvl_chg[1], lvl_chg[0]};
    assign hit       = evt & irq_en_reg;
    assign pend_next = hit | (pend_reg & ~{8{irq_read}});
    assign pulse_next = (|hit) ? `HCIG_PULSE_HALVES :
                        (fs_half_tick && pulse_reg != 2'h0) ? pulse_reg - 2'h1 : pulse_reg;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lvl_reg   <= 4'h0;
            pend_reg  <= 8'h00;
            pulse_reg <= 2'h0;
            irq_n     <= 1'b1;
        end else begin
            lvl_reg   <= lvl;
            pend_reg  <= pend_next;
            pulse_reg <= pulse_next;
            irq_n     <= pulse_mode_reg ? (pulse_next == 2'h0) : ~|pend_next;
        end
    end
endmodule // hcig_device

// >>> hcig_host.sv
// host end: drives serial frames from a small register port
// assumes the device end on the far side of hcig_link_if
`timescale 1ns/1ps
`include "hcig_consts.svh"
module hcig_host (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // link to device
    hcig_link_if.host        link,
    // user register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata
);
    import hcig_pkg::*;

    // ****************************************
    // read-data synchroniser
    // ****************************************
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic do_reg;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            do_reg <= 1'b0;
        end else begin
            s1_reg <= link.do_line;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            do_reg <= (s2_reg == s3_reg) ? s2_reg : do_reg;
        end
    end

    // ****************************************
    // user registers and link sequencer
    // ****************************************
    hcig_host_state_t state_reg;
    logic [7:0]       gaddr_reg;
    logic [15:0]      wdata_reg;
    logic [15:0]      rdata_reg;
    logic [4:0]       div_reg;
    logic [3:0]       bit_reg;
    logic             ph_reg;
    logic             cl_reg;
    logic             ce_reg;
    logic             di_reg;
    logic             tick;
    logic             busy;
    logic             go;
    logic [3:0]       bit_inc;

    assign tick    = div_reg == 5'(`HCIG_CL_HALF_CYC - 1);
    assign busy    = state_reg != H_IDLE;
    assign go      = reg_wr && reg_addr == `HCIG_REG_GO && !busy;
    assign bit_inc = bit_reg + 4'h1;
    assign link.cl = cl_reg;
    assign link.ce = ce_reg;
    assign link.di = di_reg;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            gaddr_reg <= 8'h00;
            wdata_reg <= 16'h0000;
            reg_rdata <= 16'h0000;
        end else begin
            if (reg_wr && reg_addr == `HCIG_REG_ADDR) begin
                gaddr_reg <= reg_wdata[7:0];
            end
            if (reg_wr && reg_addr == `HCIG_REG_WDATA) begin
                wdata_reg <= reg_wdata;
            end
            reg_rdata <= !reg_rd ? 16'h0000 :
                         (reg_addr == `HCIG_REG_STATUS) ? {15'h0000, busy} :
                         (reg_addr == `HCIG_REG_RDATA) ? rdata_reg : 16'h0000;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= H_IDLE;
            div_reg   <= 5'h00;
            bit_reg   <= 4'h0;
            ph_reg    <= 1'b0;
            cl_reg    <= 1'b0;
            ce_reg    <= 1'b0;
            di_reg    <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            div_reg <= (tick || go) ? 5'h00 : div_reg + 5'h01;
            case (state_reg)
                H_IDLE: begin
                    if (go) begin
                        state_reg <= H_ADDR;
                        ce_reg    <= 1'b0;
                        bit_reg   <= 4'h0;
                        ph_reg    <= 1'b0;
                        di_reg    <= gaddr_reg[0];
                    end
                end
                H_ADDR: begin
                    if (tick) begin
                        ph_reg <= ~ph_reg;
                        cl_reg <= ~ph_reg;
                        if (ph_reg) begin
                            if (bit_reg == 4'h7) begin
                                state_reg <= H_CE;
                            end else begin
                                bit_reg <= bit_inc;
                                di_reg  <= gaddr_reg[bit_inc[2:0]];
                            end
                        end
                    end
                end
                H_CE: begin
                    if (tick) begin
                        state_reg <= H_DATA;
                        ce_reg    <= 1'b1;
                        bit_reg   <= 4'h0;
                        di_reg    <= wdata_reg[0];
                    end
                end
                H_DATA: begin
                    if (tick) begin
                        ph_reg <= ~ph_reg;
                        cl_reg <= ~ph_reg;
                        if (!ph_reg) begin
                            rdata_reg[bit_reg] <= do_reg;
                        end else if (bit_reg == 4'hf) begin
                            state_reg <= H_END;
                        end else begin
                            bit_reg <= bit_inc;
                            di_reg  <= wdata_reg[bit_inc];
                        end
                    end
                end
                H_END: begin
                    if (tick) begin
                        state_reg <= H_IDLE;
                        ce_reg    <= 1'b0;
                        di_reg    <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= H_IDLE;
                    ce_reg    <= 1'b0;
                    cl_reg    <= 1'b0;
                end
            endcase
        end
    end
endmodule // hcig_host

// >>> hcig_link_checker.sv
// checker of the serial link between host and device ends
// assumes both ends share sys_clk and rstn
`timescale 1ns/1ps
module hcig_link_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // link signals
    input wire logic cl,
    input wire logic ce,
    input wire logic di,
    input wire logic do_out,
    input wire logic do_oe,
    input wire logic do_line
);
    // ****
    // bit counters per phase
    // ****
    logic       cl_q_reg;
    logic       ce_q_reg;
    logic [4:0] addr_cnt_reg;
    logic [4:0] data_cnt_reg;
    logic [4:0] addr_cnt_next;
    logic [4:0] data_cnt_next;
    wire        cl_rise = cl & ~cl_q_reg;
    wire        ce_rise = ce & ~ce_q_reg;
    wire        ce_fall = ~ce & ce_q_reg;
    assign addr_cnt_next = ce_fall ? 5'h00 : addr_cnt_reg + {4'h0, cl_rise & ~ce};
    assign data_cnt_next = ce_rise ? 5'h00 : data_cnt_reg + {4'h0, cl_rise & ce};
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cl_q_reg <= 1'b0;
            ce_q_reg <= 1'b0;
            addr_cnt_reg <= 5'h00;
            data_cnt_reg <= 5'h00;
        end else begin
            cl_q_reg <= cl;
            ce_q_reg <= ce;
            addr_cnt_reg <= addr_cnt_next;
            data_cnt_reg <= data_cnt_next;
        end
    end
    // ****
    // assertions
    // ****
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    a_addr_bits_eight: assert property ($rose(ce) |-> addr_cnt_reg == 5'h08)
        else $error("data phase began without eight address bits");
    a_data_bits_sixteen: assert property ($fell(ce) |-> data_cnt_reg == 5'h10)
        else $error("frame ended without sixteen data bits");
    a_do_release: assert property ($fell(ce) |-> ##[1:8] !do_oe)
        else $error("read data not released after chip enable fell");
    a_do_idle_off: assert property (!ce [*8] |-> !do_oe)
        else $error("read data driven while chip enable low");
    a_do_after_addr: assert property ($rose(do_oe) |-> ce && addr_cnt_reg == 5'h08)
        else $error("read data driven before address phase done");
    a_release_ce_low: assert property ($fell(do_oe) |-> !ce)
        else $error("read data released while chip enable high");
    a_do_hold_high: assert property (do_oe && cl |-> $stable(do_out))
        else $error("read bit changed while clock high");
    a_ce_cl_low: assert property ($changed(ce) |-> !cl)
        else $error("chip enable moved while clock high");
    a_di_hold: assert property (cl && $past(cl) |-> $stable(di))
        else $error("serial input changed while clock high");
    a_cl_half: assert property ($rose(cl) |=> $stable(cl) [*8])
        else $error("serial clock high phase too short");
    c_read_frame: cover property ($rose(do_oe));
    c_write_frame: cover property ($fell(ce) && !do_oe);
    c_read_end: cover property ($fell(do_oe));
endmodule // hcig_link_checker

// >>> hcig_link_if.sv
// serial control link between host and device
// assumes the bench resolves nothing further; released data reads low
`timescale 1ns/1ps
interface hcig_link_if;
    logic cl;
    logic ce;
    logic di;
    logic do_out;
    logic do_oe;
    logic do_line;
    // ****************************************
    // resolved read-data wire
    // ****************************************
    assign do_line = do_oe ? do_out : 1'b0;
    modport dev  (input cl, input ce, input di, output do_out, output do_oe);
    modport host (output cl, output ce, output di, input do_line);
endinterface

// >>> hcig_pkg.sv
// types shared by both ends of the host control link
// assumes hcig_consts.svh on the include path
package hcig_pkg;
    `include "hcig_consts.svh"
    typedef enum logic [1:0] {ST_ADDR, ST_WRITE, ST_READ, ST_SKIP} hcig_dev_state_t;
    typedef enum logic [2:0] {H_IDLE, H_ADDR, H_CE, H_DATA, H_END} hcig_host_state_t;
endpackage

// >>> testbench.sv
// testbench: host end and device end joined by the link interface
// assumes hcig_consts.svh on the include path
`timescale 1ns/1ps
`include "hcig_consts.svh"
module testbench;
    logic        sys_clk, rstn, port_direction_pin, lock_error_flag, input_present;
    logic        rate_change_event, chan_status_update, nonaudio_flag, burst_preamble_update;
    logic        slave_slip_event, emphasis_flag, fs_half_tick, reg_wr, reg_rd, irq_n;
    logic [3:0]  gp_in, gp_out, gp_oe, reg_addr;
    logic [5:0]  tick_cnt;
    logic [11:0] rate_data;
    logic [15:0] reg_wdata, reg_rdata, rd;
    int          fail_count, check_count;
    // ****
    // clock, ticks, instances
    // ****
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        tick_cnt <= tick_cnt + 6'h01;
        fs_half_tick <= (tick_cnt == 6'h3f);
    end
    hcig_link_if u_hcig_link_if ();
    hcig_device u_hcig_device (.sys_clk(sys_clk), .rstn(rstn), .link(u_hcig_link_if),
        .port_direction_pin(port_direction_pin), .gp_in(gp_in), .gp_out(gp_out),
        .gp_oe(gp_oe), .lock_error_flag(lock_error_flag), .input_present(input_present),
        .rate_change_event(rate_change_event), .chan_status_update(chan_status_update),
        .nonaudio_flag(nonaudio_flag), .burst_preamble_update(burst_preamble_update),
        .slave_slip_event(slave_slip_event), .emphasis_flag(emphasis_flag),
        .rate_data(rate_data), .fs_half_tick(fs_half_tick), .irq_n(irq_n));
    hcig_host u_hcig_host (.sys_clk(sys_clk), .rstn(rstn), .link(u_hcig_link_if),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    hcig_link_checker u_hcig_link_checker (.sys_clk(sys_clk), .rstn(rstn),
        .cl(u_hcig_link_if.cl), .ce(u_hcig_link_if.ce), .di(u_hcig_link_if.di),
        .do_out(u_hcig_link_if.do_out), .do_oe(u_hcig_link_if.do_oe),
        .do_line(u_hcig_link_if.do_line));
    // ****
    // shared tasks
    // ****
    task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task frame(input logic [7:0] ga, input logic [15:0] w);
        int n;
        reg_write(`HCIG_REG_ADDR, {8'h00, ga});
        reg_write(`HCIG_REG_WDATA, w);
        reg_write(`HCIG_REG_GO, 16'h0000);
        rd = 16'h0001;
        for (n = 0; n < 1000 && rd[0] !== 1'b0; n++) reg_read(`HCIG_REG_STATUS, rd);
        if (n == 1000) begin
            fail_count++;
            print_verdict;
        end
        reg_read(`HCIG_REG_RDATA, rd);
        wait_cyc(8);
    endtask
    task pulse_src(input int which);
        @(posedge sys_clk);
        if (which == 2) rate_change_event <= 1'b1;
        else slave_slip_event <= 1'b1;
        @(posedge sys_clk);
        rate_change_event <= 1'b0;
        slave_slip_event <= 1'b0;
        wait_cyc(6);
    endtask
    // ****
    // scenarios
    // ****
    task t_reset;
        check("reset pins", {7'h00, irq_n, gp_out, gp_oe}, 16'h0100);
        reg_read(4'hf, rd);
        check("unmapped host register", rd, 16'h0000);
    endtask
    task t_port;
        port_direction_pin <= 1'b0;
        frame(`HCIG_GRP_FUNC, 16'h50a0);
        wait_cyc(8);
        check("port out", {8'h00, gp_oe, gp_out}, 16'h00f5);
        port_direction_pin <= 1'b1;
        gp_in <= 4'h9;
        rate_data <= 12'habc;
        wait_cyc(8);
        check("port inputs", {12'h000, gp_oe}, 16'h0000);
        frame(`HCIG_GRP_RATE_RD, 16'h0000);
        check("rate group", rd, 16'habc9);
        frame(`HCIG_GRP_CS_WR, 16'h30a0);
        check("status write ignored", {12'h000, gp_out}, 16'h0005);
        frame(`HCIG_GRP_PC_RD, 16'h0000);
        check("preamble group", rd, 16'h0000);
    endtask
    task t_irq_level;
        frame(`HCIG_GRP_FUNC, 16'h4020);
        frame(`HCIG_GRP_FUNC, 16'hff80);
        lock_error_flag <= 1'b1;
        wait_cyc(4);
        check("irq on lock change", {15'h0, irq_n}, 16'h0000);
        pulse_src(2);
        check("irq on events", {15'h0, irq_n}, 16'h0000);
        wait_cyc(200);
        check("irq level held", {15'h0, irq_n}, 16'h0000);
        frame(`HCIG_GRP_IRQ_RD, 16'h0000);
        check("irq group", rd, 16'h0500);
        check("irq cleared", {15'h0, irq_n}, 16'h0001);
    endtask
    task t_irq_mask;
        frame(`HCIG_GRP_FUNC, 16'h4080);
        nonaudio_flag <= 1'b1;
        pulse_src(2);
        check("masked sources", {15'h0, irq_n}, 16'h0001);
        pulse_src(7);
        check("slip irq", {15'h0, irq_n}, 16'h0000);
        frame(`HCIG_GRP_IRQ_RD, 16'h0000);
        check("irq group live", rd, 16'h5100);
        check("irq cleared", {15'h0, irq_n}, 16'h0001);
    endtask
    task t_irq_pulse;
        frame(`HCIG_GRP_FUNC, 16'h0800);
        pulse_src(7);
        check("pulse low", {15'h0, irq_n}, 16'h0000);
        wait_cyc(58);
        check("pulse min width", {15'h0, irq_n}, 16'h0000);
        wait_cyc(128);
        check("pulse ended", {15'h0, irq_n}, 16'h0001);
        frame(`HCIG_GRP_FUNC, 16'h0200);
        frame(`HCIG_GRP_RATE_RD, 16'h0000);
        check("read disabled", rd, 16'h0000);
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        {sys_clk, rstn, lock_error_flag, input_present, rate_change_event} = 5'h00;
        {chan_status_update, nonaudio_flag, burst_preamble_update, slave_slip_event} = 4'h0;
        {emphasis_flag, fs_half_tick, reg_wr, reg_rd} = 4'h0;
        {gp_in, reg_addr, tick_cnt, rate_data, reg_wdata} = 42'h0;
        port_direction_pin = 1'b1;
        fail_count = 0;
        check_count = 0;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        wait_cyc(2);
        t_reset;
        t_port;
        t_irq_level;
        t_irq_mask;
        t_irq_pulse;
        print_verdict;
    end
endmodule // testbench
